// File: core/exchange_area_handshake.sv
// Slave end of the toggle handshake carried in the cyclic exchange areas.
// Assumes the fieldbus engine reads the input area and writes the output
// area through the ports below, on this clock.
`timescale 1ns/1ns

//Behaviour
//- Flow mode: payload starts at byte four
//- No flow: whole area data, rewritten per event
//- No flow: oversize records are truncated
//- Header: control, station, service point, length
//- Length never exceeds area size minus four
//- Control bits 7..4 zero in flow mode
//- Slave toggles input bit0 after posting block
//- Slave toggles input bit1 after consuming block
//- Slave acknowledges resync on input bit2
//- Resync clears bits 0, 1 and 3, sets ack bit2
//- Bit3 set on all but final fragment
//- Refresh and sample areas every 30 ms
//- Station address placed in header byte 1
module exchange_area_handshake
    import handshake_pkg::*;
#(
    parameter int PERIOD_CYC = PERIOD_CYCLES
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Configuration
    input wire logic flow_controlled_driver_layer,
    input wire logic [5:0] input_area_size,
    input wire logic [5:0] output_area_size,
    input wire logic [7:0] station_addr_pins,
    input wire logic [7:0] tx_sap,
    // Fieldbus side of the input area
    input wire logic [AW-1:0] in_rd_addr,
    output logic [7:0] in_rd_data,
    // Fieldbus side of the output area
    input wire logic out_wr_en,
    input wire logic [AW-1:0] out_wr_addr,
    input wire logic [7:0] out_wr_data,
    // Application record to the master
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready,
    // Application data from the master
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    output logic rx_more,
    // Status
    output logic slave_data_posted_toggle,
    output logic slave_data_consumed_toggle,
    output logic resync_ack,
    output logic more_fragments
);

    typedef struct packed {
        state_t state;
        logic [TICK_W-1:0] tick_cnt;
        logic [7:0] sa_s1;
        logic [7:0] sa_s2;
        logic [7:0] sa_s3;
        logic [7:0] station;
        logic posted;
        logic consumed;
        logic ack;
        logic more;
        logic [7:0] mctrl;
        logic [AW-1:0] rd_addr;
        logic wr_en;
        logic [AW-1:0] wr_addr;
        logic [7:0] wr_data;
        logic [5:0] cnt;
        logic [5:0] rx_len;
        logic [5:0] tx_len;
        logic [1:0] hcnt;
        logic rx_valid;
        logic [7:0] rx_data;
        logic rx_last;
        logic rx_more;
        logic tx_ready;
    } hs_state_t;

    // All other fields, toggles and outputs included, clear to zero
    localparam hs_state_t RST_STATE = '{state: S_IDLE, sa_s1: RST_STATION, sa_s2: RST_STATION,
        sa_s3: RST_STATION, station: RST_STATION, default: '0};

    hs_state_t s_q;
    hs_state_t s_d;
    logic [7:0] out_rd;
    logic tick;
    logic flow;
    logic [5:0] in_cap;
    logic [5:0] out_cap;
    logic [5:0] cnt_inc;
    logic [4:0] tx_base;

    assign flow = flow_controlled_driver_layer;
    assign in_cap = payload_cap(flow, input_area_size);
    assign out_cap = payload_cap(1'b1, output_area_size);
    assign cnt_inc = 6'(s_q.cnt + 6'h01);
    assign tx_base = flow ? OFS_PAYLOAD : OFS_CTRL;
    assign tick = (s_q.tick_cnt == TICK_W'(PERIOD_CYC - 1));

    // Input area: written here, read by the fieldbus engine
    area_mem in_area (
        .clock(clock),
        .resetn(resetn),
        .wr_en(s_q.wr_en),
        .wr_addr(s_q.wr_addr),
        .wr_data(s_q.wr_data),
        .rd_addr(in_rd_addr),
        .rd_data(in_rd_data)
    );

    // Read address taken from the next state so data lines up with s_q.rd_addr
    area_mem out_area (
        .clock(clock),
        .resetn(resetn),
        .wr_en(out_wr_en),
        .wr_addr(out_wr_addr),
        .wr_data(out_wr_data),
        .rd_addr(s_d.rd_addr),
        .rd_data(out_rd)
    );

    always_comb
    begin
        s_d = s_q;
        s_d.wr_en = 1'b0;
        s_d.rx_valid = 1'b0;
        s_d.rx_last = 1'b0;
        // Period timer for the area refresh
        s_d.tick_cnt = tick ? '0 : TICK_W'(s_q.tick_cnt + 1'b1);
        // Address switches settle through three stages
        s_d.sa_s1 = station_addr_pins;
        s_d.sa_s2 = s_q.sa_s1;
        s_d.sa_s3 = s_q.sa_s2;
        if (s_q.sa_s2 == s_q.sa_s3)
        begin
            s_d.station = s_q.sa_s3;
        end
        case (s_q.state)
            S_IDLE:
            begin
                // A tick during a pass is skipped; a pass is far shorter than the period
                if (tick)
                begin
                    s_d.rd_addr = OFS_CTRL;
                    s_d.state = S_CTRL;
                end
            end
            S_CTRL:
            begin
                s_d.mctrl = out_rd;
                if (!flow)
                begin
                    s_d.state = S_TXCHK;
                end
                else if (out_rd[MBIT_SYNC])
                begin
                    // Re-applied every period while the request is held
                    s_d.posted = 1'b0;
                    s_d.consumed = 1'b0;
                    s_d.more = 1'b0;
                    s_d.ack = 1'b1;
                    s_d.tx_len = 6'h00;
                    s_d.hcnt = 2'h0;
                    s_d.state = S_HDR;
                end
                else
                begin
                    s_d.ack = 1'b0;
                    if (out_rd[MBIT_POSTED] != s_q.consumed)
                    begin
                        s_d.rd_addr = OFS_LEN;
                        s_d.state = S_RXLEN;
                    end
                    else
                    begin
                        s_d.state = S_TXCHK;
                    end
                end
            end
            S_RXLEN:
            begin
                // Oversized length from the master is clamped to the area
                if (out_rd > {2'b00, out_cap})
                begin
                    s_d.rx_len = out_cap;
                end
                else
                begin
                    s_d.rx_len = out_rd[5:0];
                end
                s_d.cnt = 6'h00;
                if (out_rd == 8'h00)
                begin
                    s_d.consumed = ~s_q.consumed;
                    s_d.state = S_TXCHK;
                end
                else
                begin
                    s_d.rd_addr = OFS_PAYLOAD;
                    s_d.state = S_RX;
                end
            end
            S_RX:
            begin
                s_d.rx_valid = 1'b1;
                s_d.rx_data = out_rd;
                s_d.rx_more = s_q.mctrl[BIT_MORE];
                s_d.rx_last = (cnt_inc == s_q.rx_len);
                s_d.rd_addr = AW'(s_q.rd_addr + 1'b1);
                s_d.cnt = cnt_inc;
                if (cnt_inc == s_q.rx_len)
                begin
                    s_d.consumed = ~s_q.consumed;
                    s_d.state = S_TXCHK;
                end
            end
            S_TXCHK:
            begin
                s_d.cnt = 6'h00;
                s_d.hcnt = 2'h0;
                if (flow)
                begin
                    if (tx_valid && (s_q.mctrl[MBIT_CONSUMED] == s_q.posted))
                    begin
                        s_d.tx_ready = 1'b1;
                        s_d.state = S_TX;
                    end
                    else
                    begin
                        s_d.state = S_HDR;
                    end
                end
                else if (tx_valid)
                begin
                    s_d.tx_ready = 1'b1;
                    s_d.state = S_TX;
                end
                else
                begin
                    s_d.state = S_IDLE;
                end
            end
            S_TX:
            begin
                if (tx_valid && s_q.tx_ready)
                begin
                    s_d.wr_en = 1'b1;
                    s_d.wr_addr = AW'(tx_base + s_q.cnt[4:0]);
                    s_d.wr_data = tx_data;
                    s_d.cnt = cnt_inc;
                    if (tx_last || (cnt_inc == in_cap))
                    begin
                        s_d.tx_ready = 1'b0;
                        if (flow)
                        begin
                            // Remainder of a long record goes in later fragments
                            s_d.more = ~tx_last;
                            s_d.posted = ~s_q.posted;
                            s_d.tx_len = cnt_inc;
                            s_d.state = S_HDR;
                        end
                        else if (tx_last)
                        begin
                            s_d.state = S_IDLE;
                        end
                        else
                        begin
                            s_d.tx_ready = 1'b1;
                            s_d.state = S_DROP;
                        end
                    end
                end
            end
            S_DROP:
            begin
                // Rest of an oversized record is swallowed unseen
                if (tx_valid && tx_last)
                begin
                    s_d.tx_ready = 1'b0;
                    s_d.state = S_IDLE;
                end
            end
            S_HDR:
            begin
                // Header last, so the posted toggle never precedes its data
                s_d.wr_en = 1'b1;
                s_d.wr_addr = AW'(s_q.hcnt);
                case (s_q.hcnt)
                    2'h0: s_d.wr_data = {VERSION_BITS, s_q.more, s_q.ack, s_q.consumed, s_q.posted};
                    2'h1: s_d.wr_data = s_q.station;
                    2'h2: s_d.wr_data = tx_sap;
                    default: s_d.wr_data = {2'b00, s_q.tx_len};
                endcase
                s_d.hcnt = 2'(s_q.hcnt + 1'b1);
                if (s_q.hcnt == 2'h3)
                begin
                    s_d.state = S_IDLE;
                end
            end
            default:
            begin
                s_d = RST_STATE;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            s_q <= RST_STATE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign tx_ready = s_q.tx_ready;
    assign rx_valid = s_q.rx_valid;
    assign rx_data = s_q.rx_data;
    assign rx_last = s_q.rx_last;
    assign rx_more = s_q.rx_more;
    assign slave_data_posted_toggle = s_q.posted;
    assign slave_data_consumed_toggle = s_q.consumed;
    assign resync_ack = s_q.ack;
    assign more_fragments = s_q.more;

endmodule : exchange_area_handshake

// File: core/handshake_pkg.sv
// Constants, state encoding and helpers for the exchange area handshake.
// Assumes a 250 MHz core clock and exchange areas of at most 32 bytes.
package handshake_pkg;

    // Exchange area geometry
    localparam int AREA_DEPTH = 32;
    localparam int AW = 5;
    localparam logic [5:0] HDR_BYTES = 6'h04;

    // Header byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STATION = 5'h01;
    localparam logic [4:0] OFS_SAP = 5'h02;
    localparam logic [4:0] OFS_LEN = 5'h03;
    localparam logic [4:0] OFS_PAYLOAD = 5'h04;

    // Control byte bit positions, input area (slave side)
    localparam int SBIT_POSTED = 0;
    localparam int SBIT_CONSUMED = 1;
    localparam int SBIT_ACK = 2;
    localparam int BIT_MORE = 3;
    // Control byte bit positions, output area (master side)
    localparam int MBIT_CONSUMED = 0;
    localparam int MBIT_POSTED = 1;
    localparam int MBIT_SYNC = 2;
    // Protocol version nibble, bits 7..4
    localparam logic [3:0] VERSION_BITS = 4'h0;

    // Reset values
    localparam logic [7:0] RST_STATION = 8'h00;

    // Refresh period
    localparam int PERIOD_MS = 30;
    localparam int CLOCK_KHZ = 250000;
    localparam int PERIOD_CYCLES = PERIOD_MS * CLOCK_KHZ;
    localparam int TICK_W = 23;

    typedef enum logic [7:0] {
        S_IDLE  = 8'h01,
        S_CTRL  = 8'h02,
        S_RXLEN = 8'h04,
        S_RX    = 8'h08,
        S_TXCHK = 8'h10,
        S_TX    = 8'h20,
        S_DROP  = 8'h40,
        S_HDR   = 8'h80
    } state_t;

    // Payload room: whole area without flow control, else area less header
    function automatic logic [5:0] payload_cap(input logic flow, input logic [5:0] size);
        payload_cap = flow ? 6'(size - HDR_BYTES) : size;
    endfunction : payload_cap

endpackage : handshake_pkg

// File: core/area_mem.sv
// One exchange area image: single write port, registered read port.
// Assumes both ports sit on the same clock as the handshake logic.
`timescale 1ns/1ns
module area_mem
    import handshake_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Read port
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);

    logic [7:0] mem [AREA_DEPTH];

    always_ff @(posedge clock)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Reset only the read register; area contents are undefined until written
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            rd_data <= 8'h00;
        end
        else
        begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule : area_mem

// File: verif/exchange_area_handshake_sva.sv
// Port-level checker for the exchange area handshake.
// Assumes it is bound into the top module.
`timescale 1ns/1ns
module exchange_area_handshake_sva
    import handshake_pkg::*;
#(
    parameter int PERIOD_CYC = 64
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Configuration
    input wire logic flow_controlled_driver_layer,
    input wire logic [5:0] input_area_size,
    input wire logic [7:0] station_addr_pins,
    // Input area
    input wire logic [AW-1:0] in_rd_addr,
    input wire logic [7:0] in_rd_data,
    // Records
    input wire logic tx_valid,
    input wire logic tx_last,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic rx_last,
    // Status
    input wire logic slave_data_posted_toggle,
    input wire logic slave_data_consumed_toggle,
    input wire logic resync_ack,
    input wire logic more_fragments
);
    logic hdr_q;
    logic flow;
    assign flow = flow_controlled_driver_layer;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // Area checks start 16 cycles after the first resync acknowledge
    always_ff @(posedge clock)
        if (!resetn)
            hdr_q <= 1'b0;
        else if ($past(resync_ack, 16))
            hdr_q <= 1'b1;
    a_rx_consumed: assert property (rx_valid && rx_last |-> ##[0:2] $changed(slave_data_consumed_toggle))
        else $error("consumed toggle missing");
    a_resync_clear: assert property (resync_ack |->
        !slave_data_posted_toggle && !slave_data_consumed_toggle && !more_fragments) else $error("toggles not clear");
    a_noflow_no_rx: assert property (!flow |-> !rx_valid)
        else $error("rx data without flow control");
    a_noflow_steady: assert property (!flow ##1 !flow |-> $stable(slave_data_posted_toggle) && $stable(more_fragments))
        else $error("toggle moved without flow control");
    a_tx_posted: assert property (flow && tx_valid && tx_ready && tx_last |-> ##[0:2] $changed(slave_data_posted_toggle))
        else $error("posted toggle missing");
    a_ready_drop: assert property (tx_valid && tx_ready && tx_last |=> !tx_ready)
        else $error("ready held after record end");
    a_ctrl_version: assert property (hdr_q && flow && $past(flow) && $past(in_rd_addr) == OFS_CTRL
        |-> in_rd_data[7:4] == VERSION_BITS) else $error("control version bits set");
    a_station_byte: assert property (hdr_q && flow && $past(flow) && $past(in_rd_addr) == OFS_STATION
        |-> in_rd_data == station_addr_pins) else $error("station byte wrong");
    a_len_bound: assert property (hdr_q && flow && $past(flow) && $past(in_rd_addr) == OFS_LEN
        |-> in_rd_data <= {2'b00, input_area_size} - 8'h04) else $error("length over limit");
endmodule : exchange_area_handshake_sva

bind exchange_area_handshake exchange_area_handshake_sva #(.PERIOD_CYC(PERIOD_CYC)) i_sva (
    .clock(clock), .resetn(resetn), .flow_controlled_driver_layer(flow_controlled_driver_layer),
    .input_area_size(input_area_size), .station_addr_pins(station_addr_pins), .in_rd_addr(in_rd_addr),
    .in_rd_data(in_rd_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_last(rx_last), .slave_data_posted_toggle(slave_data_posted_toggle),
    .slave_data_consumed_toggle(slave_data_consumed_toggle), .resync_ack(resync_ack),
    .more_fragments(more_fragments));

// File: verif/master_model.sv
// Bus master stand-in: owns the output area, polls the input area.
// Assumes the slave read port answers one cycle after the address edge.
`timescale 1ns/1ns
module master_model
    import handshake_pkg::*;
(
    // Clock
    input wire logic clock,
    // Input area
    output logic [AW-1:0] in_rd_addr,
    input wire logic [7:0] in_rd_data,
    // Output area
    output logic out_wr_en,
    output logic [AW-1:0] out_wr_addr,
    output logic [7:0] out_wr_data
);
    logic posted_q = 1'b0;
    logic consumed_q = 1'b0;
    initial
    begin
        in_rd_addr = 5'h00;
        out_wr_en = 1'b0;
        out_wr_addr = 5'h00;
        out_wr_data = 8'h00;
    end
    task wr(input logic [AW-1:0] a, input logic [7:0] d);
        @(posedge clock);
        out_wr_en <= 1'b1;
        out_wr_addr <= a;
        out_wr_data <= d;
        @(posedge clock);
        out_wr_en <= 1'b0;
        // Released data shows garbage, not the last byte
        out_wr_data <= ~d;
    endtask : wr
    task rd(input logic [AW-1:0] a, output logic [7:0] d);
        @(posedge clock);
        in_rd_addr <= a;
        @(posedge clock);
        @(negedge clock);
        d = in_rd_data;
    endtask : rd
    task ctrl(input logic sync, input logic mf);
        if (sync)
        begin
            posted_q = 1'b0;
            consumed_q = 1'b0;
        end
        wr(OFS_CTRL, {VERSION_BITS, mf, sync, posted_q, consumed_q});
    endtask : ctrl
    task ack_tx();
        consumed_q = ~consumed_q;
        ctrl(1'b0, 1'b0);
    endtask : ack_tx
    task post(input logic [7:0] len, input logic mf, input logic [7:0] b);
        logic [7:0] d;
        d = {6'h3f, ~posted_q, 1'b1};
        for (int k = 0; k < 300 && d[SBIT_CONSUMED] !== posted_q; k++)
            rd(OFS_CTRL, d);
        if (d[SBIT_CONSUMED] !== posted_q)
            exchange_area_handshake_tb.expire();
        wr(OFS_SAP, 8'h00);
        wr(OFS_LEN, len);
        for (int i = 0; i < len; i++)
            wr(OFS_PAYLOAD + 5'(i), b + 8'(i));
        posted_q = ~posted_q;
        ctrl(1'b0, mf);
    endtask : post
endmodule : master_model

// File: verif/exchange_area_handshake_tb.sv
// Bench: master stand-in on the area ports, bench drives records.
// Assumes a short refresh period so each pass fits inside it.
`timescale 1ns/1ns
module exchange_area_handshake_tb
    import handshake_pkg::*;
;
    localparam int PER = 100;
    logic clock, resetn = 1'b0, flow = 1'b1, tx_valid = 1'b0, tx_last = 1'b0;
    logic tx_ready, rx_valid, rx_last, rx_more, posted, consumed, ack, more, out_wr_en;
    logic [5:0] size = 6'h08;
    logic [7:0] station = 8'h2d, sap = 8'h5a, tx_data = 8'h00, rx_data, out_wr_data, in_rd_data, d;
    logic [AW-1:0] in_rd_addr, out_wr_addr;
    int n_mismatch = 0, checked = 0, j;
    exchange_area_handshake #(.PERIOD_CYC(PER)) i_exchange_area_handshake (
        .clock(clock), .resetn(resetn), .flow_controlled_driver_layer(flow), .input_area_size(size),
        .output_area_size(size), .station_addr_pins(station), .tx_sap(sap), .in_rd_addr(in_rd_addr),
        .in_rd_data(in_rd_data), .out_wr_en(out_wr_en), .out_wr_addr(out_wr_addr), .out_wr_data(out_wr_data),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_last(rx_last), .rx_more(rx_more), .slave_data_posted_toggle(posted),
        .slave_data_consumed_toggle(consumed), .resync_ack(ack), .more_fragments(more));
    master_model i_master_model (.clock(clock), .in_rd_addr(in_rd_addr), .in_rd_data(in_rd_data),
        .out_wr_en(out_wr_en), .out_wr_addr(out_wr_addr), .out_wr_data(out_wr_data));
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task final_report();
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report
    task expire();
        n_mismatch++;
        $display("Error at %0t: wait ran out", $time);
        final_report();
    endtask : expire
    task wait_sig(input int s, input logic v);
        for (int k = 0; k < 4 * PER; k++)
        begin
            @(negedge clock);
            if ((s == 0 ? posted : s == 1 ? consumed : ack) === v)
                return;
        end
        expire();
    endtask : wait_sig
    task area(input logic [AW-1:0] a, input logic [7:0] e);
        i_master_model.rd(a, d);
        check(d, e);
    endtask : area
    task send_rec(input int n, input logic [7:0] b);
        int i;
        i = 0;
        for (int k = 0; k < 2000 && i < n; k++)
        begin
            @(posedge clock);
            tx_valid <= 1'b1;
            tx_data <= b + 8'(i);
            tx_last <= i == n - 1;
            @(negedge clock);
            if (tx_ready === 1'b1)
                i++;
        end
        @(posedge clock);
        tx_valid <= 1'b0;
        if (i < n)
            expire();
    endtask : send_rec
    initial
    begin
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        i_master_model.ctrl(1'b1, 1'b0);
        wait_sig(2, 1'b1);
        // Request held one more period, a scaled-down hold time
        repeat (PER) @(posedge clock);
        @(negedge clock);
        check({4'h0, more, ack, consumed, posted}, 8'h04);
        area(OFS_CTRL, 8'h04);
        area(OFS_STATION, 8'h2d);
        area(OFS_SAP, 8'h5a);
        area(OFS_LEN, 8'h00);
        i_master_model.ctrl(1'b0, 1'b0);
        wait_sig(2, 1'b0);
        $display("Test resync done");
        i_master_model.post(8'h03, 1'b1, 8'ha1);
        j = 0;
        for (int k = 0; k < 4 * PER && j < 3; k++)
        begin
            @(negedge clock);
            if (rx_valid === 1'b1)
            begin
                check(rx_data, 8'ha1 + 8'(j));
                check({6'h00, rx_more, rx_last}, {7'h01, j == 2});
                j++;
            end
        end
        check(8'(j), 8'h03);
        wait_sig(1, 1'b1);
        i_master_model.post(8'h00, 1'b0, 8'h00);
        wait_sig(1, 1'b0);
        $display("Test receive done");
        fork
            send_rec(6, 8'h30);
        join_none
        wait_sig(0, 1'b1);
        repeat (PER) @(posedge clock);
        @(negedge clock);
        check({6'h00, more, posted}, 8'h03);
        area(OFS_LEN, 8'h04);
        for (int i = 0; i < 4; i++)
            area(OFS_PAYLOAD + 5'(i), 8'h30 + 8'(i));
        i_master_model.ack_tx();
        wait_sig(0, 1'b0);
        repeat (12) @(posedge clock);
        @(negedge clock);
        check({7'h00, more}, 8'h00);
        area(OFS_LEN, 8'h02);
        area(OFS_PAYLOAD, 8'h34);
        area(OFS_PAYLOAD + 5'h01, 8'h35);
        i_master_model.ack_tx();
        $display("Test transmit done");
        // Over-long block from the master is clamped to the area
        i_master_model.post(8'h09, 1'b0, 8'hc0);
        j = 0;
        for (int k = 0; k < 4 * PER; k++)
        begin
            @(negedge clock);
            if (rx_valid === 1'b1)
            begin
                check(rx_data, 8'hc0 + 8'(j));
                check({7'h00, rx_last}, {7'h00, j == 3});
                j++;
            end
        end
        check(8'(j), 8'h04);
        check({7'h00, consumed}, 8'h01);
        // Resync in mid-run, with a toggle set beforehand
        i_master_model.ctrl(1'b1, 1'b0);
        wait_sig(2, 1'b1);
        check({4'h0, more, ack, consumed, posted}, 8'h04);
        i_master_model.ctrl(1'b0, 1'b0);
        wait_sig(2, 1'b0);
        $display("Test clamp and resync done");
        @(posedge clock);
        flow <= 1'b0;
        send_rec(10, 8'h50);
        repeat (12) @(posedge clock);
        // Each event read out before the next replaces it
        for (int i = 0; i < 8; i++)
            area(5'(i), 8'h50 + 8'(i));
        send_rec(3, 8'h60);
        repeat (12) @(posedge clock);
        for (int i = 0; i < 3; i++)
            area(5'(i), 8'h60 + 8'(i));
        $display("Test no flow control done");
        final_report();
    end
endmodule : exchange_area_handshake_tb
